// ---- glue_pkg.sv ----
// Package with constants shared by the processor end and the memory glue end
package glue_pkg;
  // ===========================================================
  // Address space
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BANK_W = 11;
  localparam int unsigned SEL_BIT = 11;
  localparam logic [11:0] PROM_LAST = 12'h07FF;
  localparam logic [11:0] RAM_FIRST = 12'h0800;
  // ===========================================================
  // Reset values
  localparam logic [11:0] ADDR_RST = 12'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic STROBE_IDLE = 1'h1; // Strobes idle high
  localparam logic PROCESSOR_CLOCK_OUTPUT_IDLE = 1'h0;
  localparam logic MODE_RST = 1'h0;
  // ===========================================================
  // Processor cycle timing in reference clocks
  // Long enough for the glue input flops and its data register
  localparam int unsigned HALF_CYC = 4;
  localparam logic [1:0] HALF_LAST = 2'(HALF_CYC - 1);
  localparam int unsigned RAM_WORDS = 2048;
  // Kinds of processor access
  typedef enum logic [1:0] {ACC_FETCH, ACC_TBL_READ, ACC_TBL_WRITE} acc_kind_e;
endpackage

// ---- mem_bus_if.sv ----
// Interface joining processor external memory bus and memory glue
`timescale 1ns/10ps
`default_nettype none
interface mem_bus_if;
  import glue_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic mem_read_strobe_n;
  logic write_strobe_n;
  logic processor_clock_output;
  logic program_memory_mode_select;
  modport processor (
    output addr, wdata, mem_read_strobe_n, write_strobe_n,
    output processor_clock_output, program_memory_mode_select,
    input rdata
  );
  modport glue (
    input addr, wdata, mem_read_strobe_n, write_strobe_n,
    input processor_clock_output, program_memory_mode_select,
    output rdata
  );
endinterface
`default_nettype wire

// ---- sync2.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // Two stages, first read only by second
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= RST;
      q_o <= RST;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- mem_glue.sv ----
// Memory glue end: decode, address latch, output enables, PROM and RAM banks
// Function
// - Addresses 0 to 7FF select PROM
// - Addresses 800 to FFF select RAM
// - Top address bit alone picks bank
// - Reads served on fetches and table reads
// - Writes reach RAM only; PROM ignores
// - Processor reads by address and strobe low
// - Latch transparent while buffered strobe high
// - Output drivers off until clock output high
// - Enable holds until clock falls or strobe rises
// - Processor writes with write strobe instead
// - Buffered strobe high in first half
// - Latch holds until write strobe high again
// - Every access completes in one cycle
// - Mode select 0 puts all program external
// - Mode select 1 keeps internal ROM
// - Mode 1 needs changed decode for overlap; here decode unchanged, overlap only flagged
// - Direct strobe enable only with buffers
`timescale 1ns/10ps
`default_nettype none
module mem_glue
  import glue_pkg::*;
#(
  parameter logic [15:0] PROM_FILL = 16'h0000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Processor bus
  mem_bus_if.glue bus,
  // User side status
  output logic prom_sel_o,
  output logic ram_sel_o,
  output logic read_output_enable_o,
  output logic overlap_access_o
);
  // ===========================================================
  // Pin synchronisation
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wdata_s;
  logic rd_n_s;
  logic wr_n_s;
  logic clk_s;
  logic mode_s;
  // Address and write data words
  sync2 #(.W(ADDR_W), .RST(ADDR_RST)) u_sync_addr (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .d_i(bus.addr),
    .q_o(addr_s)
  );
  sync2 #(.W(DATA_W), .RST(DATA_RST)) u_sync_data (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .d_i(bus.wdata),
    .q_o(wdata_s)
  );
  // Strobes reset to idle high, so no false edge follows reset
  sync2 #(.W(1), .RST(STROBE_IDLE)) u_sync_rd (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .d_i(bus.mem_read_strobe_n),
    .q_o(rd_n_s)
  );
  sync2 #(.W(1), .RST(STROBE_IDLE)) u_sync_wr (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .d_i(bus.write_strobe_n),
    .q_o(wr_n_s)
  );
  // Clock output and mode select idle low
  sync2 #(.W(1), .RST(PROCESSOR_CLOCK_OUTPUT_IDLE)) u_sync_clk (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .d_i(bus.processor_clock_output),
    .q_o(clk_s)
  );
  sync2 #(.W(1), .RST(MODE_RST)) u_sync_mode (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .d_i(bus.program_memory_mode_select),
    .q_o(mode_s)
  );
  // ===========================================================
  // Buffered write strobe and address latch
  logic buffered_write_strobe;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] lat_addr;
  logic wr_n_d1_q;
  logic wr_rise;
  // High through the first half of every cycle
  assign buffered_write_strobe = wr_n_s;
  // Latch register follows the address while transparent
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      addr_q <= ADDR_RST;
    else if (buffered_write_strobe)
      addr_q <= addr_s;
  end
  // Transparent while strobe high, held value while low
  assign lat_addr = buffered_write_strobe ? addr_s : addr_q;
  // Delayed write strobe for its rising edge
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      wr_n_d1_q <= STROBE_IDLE;
    else
      wr_n_d1_q <= wr_n_s;
  end
  // Write lands as the strobe returns high
  assign wr_rise = !wr_n_d1_q && wr_n_s;
  // ===========================================================
  // Bank decode from top address bit and its inverse
  logic prom_sel;
  logic ram_sel;
  logic [BANK_W-1:0] rd_index;
  logic [BANK_W-1:0] wr_index;
  logic wr_to_ram;
  assign ram_sel = lat_addr[SEL_BIT];
  assign prom_sel = ~lat_addr[SEL_BIT];
  // Read side decodes the latch output
  assign rd_index = lat_addr[BANK_W-1:0];
  // Write side decodes the address held past the strobe
  assign wr_index = addr_q[BANK_W-1:0];
  assign wr_to_ram = addr_q[SEL_BIT];
  // ===========================================================
  // Storage
  // Two banks of flip-flops indexed by the low address bits
  logic [DATA_W-1:0] ram_q [RAM_WORDS];
  logic [DATA_W-1:0] prom_q [RAM_WORDS];
  // Write into RAM on write strobe rising; PROM region ignored
  always_ff @(posedge ref_clk_i)
  begin
    if (wr_rise && wr_to_ram)
      ram_q[wr_index] <= wdata_s;
  end
  // PROM contents fixed
  always_ff @(posedge ref_clk_i)
  begin
    for (int i = 0; i < RAM_WORDS; i++)
      prom_q[i] <= PROM_FILL;
  end
  // Word addressed in the selected bank
  logic [DATA_W-1:0] bank_word;
  always_comb
  begin
    if (ram_sel)
      bank_word = ram_q[rd_index];
    else
      bank_word = prom_q[rd_index];
  end
  // ===========================================================
  // Read enable gated by clock output and read strobe
  logic acc_active;
  logic rd_en;
  // Any strobe low marks an access
  assign acc_active = !rd_n_s || !wr_n_s;
  // Drivers wait for clock high, drop at clock low or strobe high
  assign rd_en = !rd_n_s && clk_s;
  // Registered enable for the user side
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      read_output_enable_o <= 1'b0;
    else
      read_output_enable_o <= rd_en;
  end
  // Read data, single cycle, no waits
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      bus.rdata <= DATA_RST;
    else if (rd_en)
      bus.rdata <= bank_word;
    else
      bus.rdata <= DATA_RST;
  end
  // ===========================================================
  // Status outputs
  // PROM bank flag while a strobe is low
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      prom_sel_o <= 1'b0;
    else
      prom_sel_o <= prom_sel && acc_active;
  end
  // RAM bank flag while a strobe is low
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      ram_sel_o <= 1'b0;
    else
      ram_sel_o <= ram_sel && acc_active;
  end
  // Mode one access to the low region the internal ROM may shadow
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      overlap_access_o <= 1'b0;
    else
      overlap_access_o <= mode_s && prom_sel && acc_active;
  end
endmodule
`default_nettype wire

// ---- proc_end.sv ----
// Processor end: drives one memory cycle per request on the external bus
`timescale 1ns/10ps
`default_nettype none
module proc_end
  import glue_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Bus
  mem_bus_if.processor bus,
  // User request
  input wire logic req_i,
  input wire logic [1:0] kind_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic mode_i,
  // User answer
  output logic busy_o,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} st_e;
  st_e st_q;
  logic [1:0] cnt_q;
  logic is_wr_q;
  logic half_end;
  assign half_end = (cnt_q == HALF_LAST);
  // Cycle sequencer: low half then high half
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 2'h0;
      is_wr_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
          if (req_i)
          begin
            st_q <= ST_LOW;
            cnt_q <= 2'h0;
            is_wr_q <= (kind_i == 2'(ACC_TBL_WRITE));
          end
        ST_LOW:
          if (half_end)
          begin
            st_q <= ST_HIGH;
            cnt_q <= 2'h0;
          end
          else
            cnt_q <= cnt_q + 2'h1;
        ST_HIGH:
          if (half_end)
            st_q <= ST_IDLE;
          else
            cnt_q <= cnt_q + 2'h1;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
  // Bus pins
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      bus.addr <= ADDR_RST;
      bus.wdata <= DATA_RST;
      bus.mem_read_strobe_n <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.processor_clock_output <= 1'b0;
      bus.program_memory_mode_select <= 1'b0;
    end
    else
    begin
      bus.program_memory_mode_select <= mode_i;
      bus.processor_clock_output <= (st_q == ST_LOW && half_end) || (st_q == ST_HIGH && !half_end);
      if (st_q == ST_IDLE && req_i)
      begin
        bus.addr <= addr_i;
        bus.wdata <= wdata_i;
        bus.mem_read_strobe_n <= (kind_i == 2'(ACC_TBL_WRITE));
      end
      else if (st_q == ST_HIGH && half_end)
        bus.mem_read_strobe_n <= 1'b1;
      // Write strobe only in second half
      bus.write_strobe_n <= !(is_wr_q && ((st_q == ST_LOW && half_end) || (st_q == ST_HIGH && !half_end)));
    end
  end
  // Answer
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= DATA_RST;
    end
    else
    begin
      busy_o <= (st_q != ST_IDLE) || req_i;
      done_o <= (st_q == ST_HIGH) && half_end;
      if (st_q == ST_HIGH && half_end && !is_wr_q)
        rdata_o <= bus.rdata;
    end
  end
endmodule
`default_nettype wire

// ---- mem_bus_props.sv ----
// Checker watching the memory bus between processor end and glue end
`timescale 1ns/10ps
`default_nettype none
module mem_bus_props
  import glue_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Bus
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic mem_read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic processor_clock_output,
  input wire logic program_memory_mode_select
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // ============================================================
  // Strobe order and timing
  a_one_strobe_only: assert property (mem_read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  a_clk_after_read: assert property ($fell(mem_read_strobe_n) |-> ##[1:4] processor_clock_output)
    else $error("clock output late in read");
  a_write_late_half: assert property ($fell(write_strobe_n) |-> processor_clock_output)
    else $error("write strobe in first half");
  a_read_ends: assert property ($fell(mem_read_strobe_n) |-> ##[1:8] $rose(mem_read_strobe_n))
    else $error("read cycle too long");
  a_write_ends: assert property ($fell(write_strobe_n) |-> ##[1:6] $rose(write_strobe_n))
    else $error("write cycle too long");
  a_clk_falls_read: assert property ($rose(processor_clock_output) && !mem_read_strobe_n |-> ##[1:4]
    $fell(processor_clock_output))
    else $error("clock output stuck high");
  // ============================================================
  // Address and write data held through a cycle, read data gated by clock output
  a_addr_hold_read: assert property (!mem_read_strobe_n && !$past(mem_read_strobe_n) |-> $stable(addr))
    else $error("address moved in read");
  a_addr_hold_write: assert property (!write_strobe_n && !$past(write_strobe_n) |-> $stable(addr))
    else $error("address moved in write");
  a_wdata_hold: assert property (!write_strobe_n && !$past(write_strobe_n) |-> $stable(wdata))
    else $error("write data moved");
  a_rdata_gated: assert property (rdata != DATA_RST |-> $past(processor_clock_output, 3))
    else $error("read data driven before clock output high");
  // Main scenarios
  c_read: cover property ($fell(mem_read_strobe_n));
  c_write: cover property ($fell(write_strobe_n));
  c_mode_one: cover property (program_memory_mode_select && !mem_read_strobe_n);
endmodule
`default_nettype wire

// ---- direct_memory_expansion_glue_tb.sv ----
// Testbench joining the processor end to the memory glue end
`timescale 1ns/10ps
`default_nettype none
module direct_memory_expansion_glue_tb
  import glue_pkg::*;
;
  localparam logic [15:0] FILL = 16'hA5C3;
  logic ref_clk_i;
  logic reset_i;
  logic req_i;
  logic [1:0] kind_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic mode_i;
  logic busy_o;
  logic done_o;
  logic [DATA_W-1:0] rdata_o;
  logic prom_sel_o;
  logic ram_sel_o;
  logic read_output_enable_o;
  logic overlap_access_o;
  logic [4:0] seen;
  int miscompares;
  int num_checks;
  mem_bus_if bus ();
  proc_end proc_end_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(bus.processor), .req_i(req_i),
    .kind_i(kind_i), .addr_i(addr_i), .wdata_i(wdata_i), .mode_i(mode_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o));
  mem_glue #(.PROM_FILL(FILL)) mem_glue_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus(bus.glue),
    .prom_sel_o(prom_sel_o), .ram_sel_o(ram_sel_o), .read_output_enable_o(read_output_enable_o),
    .overlap_access_o(overlap_access_o));
  mem_bus_props mem_bus_props_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr(bus.addr), .wdata(bus.wdata),
    .rdata(bus.rdata), .mem_read_strobe_n(bus.mem_read_strobe_n), .write_strobe_n(bus.write_strobe_n),
    .processor_clock_output(bus.processor_clock_output),
    .program_memory_mode_select(bus.program_memory_mode_select));
  // ============================================================
  // Compare, verdict and one bus cycle
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Flags: both, overlap, enable, ram, prom
  task automatic collect();
    seen = seen | {prom_sel_o & ram_sel_o, overlap_access_o, read_output_enable_o, ram_sel_o, prom_sel_o};
  endtask
  task automatic cycle(input logic [1:0] k, input logic [11:0] a, input logic [15:0] d, input logic m);
    int n;
    seen = 5'h00;
    kind_i = k;
    addr_i = a;
    wdata_i = d;
    mode_i = m;
    req_i = 1'b1;
    @(negedge ref_clk_i);
    req_i = 1'b0;
    check("busy", 16'(busy_o), 16'h0001);
    n = 0;
    while (done_o !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk_i);
      collect();
      n++;
    end
    if (n == 20)
      miscompares++;
    check("cycle_len", 16'(n), 16'(2 * HALF_CYC));
    repeat (3)
    begin
      @(negedge ref_clk_i);
      collect();
    end
    check("idle", 16'(busy_o), 16'h0000);
    check("both_sel", 16'(seen[4]), 16'h0000);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_prom_reads();
    cycle(2'd0, 12'h000, 16'h0000, 1'b0);
    check("prom_lo", rdata_o, FILL);
    check("sel_lo", 16'(seen[1:0]), 16'h0001);
    cycle(2'd1, 12'h7FF, 16'h0000, 1'b0);
    check("prom_hi", rdata_o, FILL);
    check("oe_read", 16'(seen[2]), 16'h0001);
  endtask
  task automatic t_ram_rw();
    cycle(2'd2, 12'h800, 16'h1234, 1'b0);
    check("sel_wr", 16'(seen[2:0]), 16'h0002);
    cycle(2'd2, 12'hFFF, 16'hBEEF, 1'b0);
    cycle(2'd1, 12'h800, 16'h0000, 1'b0);
    check("ram_lo", rdata_o, 16'h1234);
    cycle(2'd0, 12'hFFF, 16'h0000, 1'b0);
    check("ram_hi", rdata_o, 16'hBEEF);
  endtask
  task automatic t_prom_write();
    cycle(2'd2, 12'h7FF, 16'h0F0F, 1'b0);
    cycle(2'd0, 12'h7FF, 16'h0000, 1'b0);
    check("prom_kept", rdata_o, FILL);
    cycle(2'd0, 12'hFFF, 16'h0000, 1'b0);
    check("ram_kept", rdata_o, 16'hBEEF);
  endtask
  task automatic t_mode_one();
    cycle(2'd0, 12'h010, 16'h0000, 1'b1);
    check("overlap", 16'(seen[3]), 16'h0001);
    cycle(2'd0, 12'h810, 16'h0000, 1'b1);
    check("no_overlap", 16'(seen[3]), 16'h0000);
  endtask
  // Clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Watchdog
  initial
  begin
    #20000;
    miscompares++;
    close_out();
  end
  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    req_i = 1'b0;
    kind_i = 2'd0;
    addr_i = 12'h000;
    wdata_i = 16'h0000;
    mode_i = 1'b0;
    seen = 5'h00;
    repeat (5) @(negedge ref_clk_i);
    reset_i = 1'b0;
    t_prom_reads();
    t_ram_rw();
    t_prom_write();
    t_mode_one();
    close_out();
  end
endmodule
`default_nettype wire
